// ### rtl/lsp_pkg.sv
// constants, types and the host register map for the serial register port
// assumes a 100 MHz system clock on both ends
package lsp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
    localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
    localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [7:0] TEST_BASE = 8'h6B;
    localparam int READ_FLAG_BIT = 7;
    localparam int REG_DEPTH = 128;
    localparam logic [7:0] REG_RESET = 8'h00;

    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_WR_MAX_HZ = 13_000_000;
    localparam int SCLK_RD_MAX_HZ = 6_000_000;
    // read limit is the tighter one, so one rate serves both
    localparam int SCLK_HALF_CYC =
        (CLK_HZ + 2 * SCLK_RD_MAX_HZ - 1) / (2 * SCLK_RD_MAX_HZ);
    localparam int CMD_WAIT_NS = 2000;
    localparam int CMD_WAIT_CYC =
        (CMD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_RDATA_LSB = 8;

    typedef enum logic [1:0] {
        LSP_IDLE = 2'b00,
        LSP_SHIFT = 2'b01,
        LSP_GAP = 2'b11
    } lsp_hstate_t;
endpackage

// ### rtl/lsp_link_if.sv
// four-wire serial link between host and device
// assumes each end samples the other's lines with its own clock
`timescale 1ns/1ps
interface lsp_link_if;
    logic sclk;
    logic ce;
    logic serial_in;
    logic serial_out;
    modport host (output sclk, output ce, output serial_in, input serial_out);
    modport dev (input sclk, input ce, input serial_in, output serial_out);
endinterface

// ### rtl/lsp_dev.sv
// device end: serial receiver, address decoder, register file, tx register
// assumes link lines are asynchronous and are synchronised here
// Notes on behaviour
// - host never writes addresses 6Bh and above
// - 16-bit shift register, address decode, 8-bit transmit
// - serial input sampled on serial clock rise
// - write serial clock at most 13 MHz
// - read serial clock at most 6 MHz
// - write frame: address then data, MSB first
// - read frame: address MSB first, eight bits back
// - bits accepted only while chip enable high
// - display RAM is never readable here
// - link is clock, data in, data out, enable
// - host waits 2 us after each write
`timescale 1ns/1ps
module lsp_dev #(
    parameter int DEPTH = lsp_pkg::REG_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    lsp_link_if.dev link,
    output logic wr_stb_o,
    output logic [lsp_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [lsp_pkg::DATA_W-1:0] wr_data_o
);
    logic [2:0] sclk_sync_q;
    logic [1:0] ce_sync_q;
    logic [1:0] din_sync_q;
    logic rise;
    logic fall;
    logic ce_on;
    logic [lsp_pkg::CNT_W-1:0] cnt_q;
    logic [lsp_pkg::FRAME_BITS-1:0] shift_q;
    logic [lsp_pkg::FRAME_BITS-1:0] word;
    logic [lsp_pkg::DATA_W-1:0] tx_q;
    logic reading_q;
    logic [lsp_pkg::DATA_W-1:0] regs_q [DEPTH];
    logic commit;
    logic load_tx;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_sync_q <= 3'h0;
            ce_sync_q <= 2'h0;
            din_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
            ce_sync_q <= {ce_sync_q[0], link.ce};
            din_sync_q <= {din_sync_q[0], link.serial_in};
        end
    end

    assign ce_on = ce_sync_q[1];
    assign rise = sclk_sync_q[1] & ~sclk_sync_q[2] & ce_on;
    assign fall = ~sclk_sync_q[1] & sclk_sync_q[2] & ce_on;
    assign word = {shift_q[lsp_pkg::FRAME_BITS-2:0], din_sync_q[1]};
    // write commits only on the sixteenth rise inside one enable
    assign commit = rise && (cnt_q == lsp_pkg::CNT_FRAME_LAST) &&
        !word[lsp_pkg::DATA_W + lsp_pkg::READ_FLAG_BIT];
    assign load_tx = rise && (cnt_q == lsp_pkg::CNT_ADDR_LAST) &&
        word[lsp_pkg::READ_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////
    // receive shift register, MSB first
    always_ff @(posedge clk_i) begin
        if (rst_i || !ce_on) begin
            cnt_q <= '0;
            shift_q <= '0;
        end else if (rise && cnt_q != lsp_pkg::CNT_FULL) begin
            shift_q <= word;
            cnt_q <= cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file; test range 6Bh up stays read/write, reset zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                regs_q[i] <= lsp_pkg::REG_RESET;
            end
        end else if (commit && int'(word[lsp_pkg::FRAME_BITS-1 -:
            lsp_pkg::ADDR_W]) < DEPTH) begin
            regs_q[word[lsp_pkg::FRAME_BITS-2 -: lsp_pkg::ADDR_W-1]] <=
                word[lsp_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_stb_o <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= '0;
        end else begin
            wr_stb_o <= commit;
            if (commit) begin
                wr_addr_o <= word[lsp_pkg::FRAME_BITS-1 -: lsp_pkg::ADDR_W];
                wr_data_o <= word[lsp_pkg::DATA_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit register: loaded after the address, shifted on falls
    // only registers are returned, no display memory
    always_ff @(posedge clk_i) begin
        if (rst_i || !ce_on) begin
            tx_q <= '0;
            reading_q <= 1'b0;
        end else if (load_tx) begin
            reading_q <= 1'b1;
            if (int'(word[lsp_pkg::ADDR_W-2:0]) < DEPTH) begin
                tx_q <= regs_q[word[lsp_pkg::ADDR_W-2:0]];
            end else begin
                tx_q <= '0;
            end
        end else if (fall && reading_q && cnt_q > lsp_pkg::CNT_DATA_FIRST) begin
            tx_q <= {tx_q[lsp_pkg::DATA_W-2:0], 1'b0};
        end
    end

    // tx register is zero outside a read, so its top flop drives the pin
    assign link.serial_out = tx_q[lsp_pkg::DATA_W-1];
endmodule

// ### rtl/lsp_host.sv
// host end: Wishbone slave that runs frames on the serial link
// assumes classic single-cycle Wishbone masters and a 100 MHz clock
`timescale 1ns/1ps
module lsp_host #(
    parameter int HALF_CYC = lsp_pkg::SCLK_HALF_CYC,
    parameter int WAIT_CYC = lsp_pkg::CMD_WAIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    lsp_link_if.host link
);
    lsp_pkg::lsp_hstate_t state_q;
    logic [lsp_pkg::TIMER_W-1:0] div_q;
    logic [lsp_pkg::CNT_W-1:0] bit_q;
    logic phase_q;
    logic [lsp_pkg::FRAME_BITS-1:0] frame_q;
    logic rd_q;
    logic [lsp_pkg::DATA_W-1:0] rx_q;
    logic [lsp_pkg::DATA_W-1:0] rdata_q;
    logic refused_q;
    logic sclk_q;
    logic ce_q;
    logic [1:0] so_sync_q;
    logic req;
    logic cmd_wr;
    logic [lsp_pkg::ADDR_W-1:0] cmd_addr;
    logic cmd_rd;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: ack one cycle after request, command taken at ack
    assign req = wb_cyc_i & wb_stb_i;
    assign cmd_wr = req && wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3 &&
        wb_adr_i == lsp_pkg::REG_CMD;
    assign cmd_addr = wb_dat_i[lsp_pkg::CMD_ADDR_LSB +: lsp_pkg::ADDR_W];
    assign cmd_rd = cmd_addr[lsp_pkg::READ_FLAG_BIT];

    always_comb begin
        status = '0;
        status[lsp_pkg::ST_BUSY_BIT] = (state_q != lsp_pkg::LSP_IDLE);
        status[lsp_pkg::ST_REFUSED_BIT] = refused_q;
        status[lsp_pkg::ST_RDATA_LSB +: lsp_pkg::DATA_W] = rdata_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= (wb_adr_i == lsp_pkg::REG_STATUS) ? status : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial data out pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            so_sync_q <= 2'h0;
        end else begin
            so_sync_q <= {so_sync_q[0], link.serial_out};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer; clock half period meets both limits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= lsp_pkg::LSP_IDLE;
            div_q <= '0;
            bit_q <= '0;
            phase_q <= 1'b0;
            frame_q <= '0;
            rd_q <= 1'b0;
            rx_q <= '0;
            rdata_q <= '0;
            refused_q <= 1'b0;
            sclk_q <= 1'b0;
            ce_q <= 1'b0;
        end else begin
            unique case (state_q)
                lsp_pkg::LSP_IDLE: begin
                    if (cmd_wr) begin
                        if (!cmd_rd && cmd_addr >= lsp_pkg::TEST_BASE) begin
                            refused_q <= 1'b1;
                        end else begin
                            refused_q <= 1'b0;
                            frame_q <= wb_dat_i[lsp_pkg::FRAME_BITS-1:0];
                            rd_q <= cmd_rd;
                            ce_q <= 1'b1;
                            div_q <= '0;
                            bit_q <= '0;
                            phase_q <= 1'b0;
                            state_q <= lsp_pkg::LSP_SHIFT;
                        end
                    end
                end
                lsp_pkg::LSP_SHIFT: begin
                    if (int'(div_q) == HALF_CYC - 1) begin
                        div_q <= '0;
                        if (!phase_q) begin
                            sclk_q <= 1'b1;
                            phase_q <= 1'b1;
                            if (rd_q && bit_q >= lsp_pkg::CNT_DATA_FIRST) begin
                                rx_q <= {rx_q[lsp_pkg::DATA_W-2:0],
                                    so_sync_q[1]};
                            end
                        end else begin
                            sclk_q <= 1'b0;
                            phase_q <= 1'b0;
                            frame_q <= {frame_q[lsp_pkg::FRAME_BITS-2:0],
                                1'b0};
                            if (bit_q == lsp_pkg::CNT_FRAME_LAST) begin
                                ce_q <= 1'b0;
                                state_q <= lsp_pkg::LSP_GAP;
                            end else begin
                                bit_q <= bit_q + 1'b1;
                            end
                        end
                    end else begin
                        div_q <= div_q + 1'b1;
                    end
                end
                lsp_pkg::LSP_GAP: begin
                    if (rd_q) begin
                        rdata_q <= rx_q;
                    end
                    if (int'(div_q) == WAIT_CYC - 1) begin
                        div_q <= '0;
                        state_q <= lsp_pkg::LSP_IDLE;
                    end else begin
                        div_q <= div_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= lsp_pkg::LSP_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.ce = ce_q;
    // read data phase sends zeros
    assign link.serial_in = ce_q & frame_q[lsp_pkg::FRAME_BITS-1] &
        ~(rd_q && bit_q >= lsp_pkg::CNT_DATA_FIRST);
endmodule

// ### sim/lsp_link_sva.sv
// checker for the four-wire serial link between host and device
// assumes clk_i and rst_i are the host clock and its reset
`timescale 1ns/1ps
module lsp_link_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic ce,
    input wire logic serial_in,
    input wire logic serial_out
);
    logic sclk_q;
    logic rise;
    logic rd_q;
    logic [4:0] cnt_q;
    logic [5:0] per_q;
    logic [5:0] hi_q;
    logic [7:0] lo_q;
    assign rise = sclk && !sclk_q;
    always_ff @(posedge clk_i) begin
        sclk_q <= sclk;
    end
    // serial clock rises within the current frame
    always_ff @(posedge clk_i) begin
        if (rst_i || !ce) cnt_q <= 5'h00;
        else if (rise) cnt_q <= cnt_q + 5'h01;
    end
    // cycles since the last serial clock rise
    always_ff @(posedge clk_i) begin
        if (rst_i || rise) per_q <= 6'h00;
        else if (per_q != 6'h3F) per_q <= per_q + 6'h01;
    end
    // cycles the serial clock has stood high
    always_ff @(posedge clk_i) begin
        if (rst_i || !sclk) hi_q <= 6'h00;
        else if (hi_q != 6'h3F) hi_q <= hi_q + 6'h01;
    end
    // cycles enable has stood low, saturating; reset counts as a long gap
    always_ff @(posedge clk_i) begin
        if (rst_i) lo_q <= 8'hFF;
        else if (ce) lo_q <= 8'h00;
        else if (lo_q != 8'hFF) lo_q <= lo_q + 8'h01;
    end
    // first address bit marks a read frame
    always_ff @(posedge clk_i) begin
        if (rst_i) rd_q <= 1'b0;
        else if (ce && rise && cnt_q == 5'h00) rd_q <= serial_in;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_sclk_idle_low: assert property (!ce |-> !sclk)
        else $error("serial clock high outside a frame");
    a_frame_bits: assert property ($fell(ce) |-> cnt_q == 5'h10)
        else $error("frame ended without sixteen bits");
    a_ce_sclk_fall: assert property ($fell(ce) |-> $fell(sclk))
        else $error("enable and clock did not fall together");
    a_din_at_fall: assert property (
        ce && $past(ce) && $changed(serial_in) |-> $fell(sclk))
        else $error("data changed away from a clock fall");
    a_din_stable: assert property (sclk |-> $stable(serial_in))
        else $error("data moved while serial clock high");
    a_sclk_rate: assert property (
        rise && cnt_q != 5'h00 |-> per_q >= 6'h10)
        else $error("serial clock faster than allowed");
    a_sclk_high_len: assert property (
        $fell(sclk) |-> hi_q == 6'(lsp_pkg::SCLK_HALF_CYC))
        else $error("serial clock high phase wrong");
    a_addr_quiet: assert property (
        ce && cnt_q >= 5'h02 && cnt_q <= 5'h07 |-> !serial_out)
        else $error("device drove data during address");
    a_write_quiet: assert property (
        ce && cnt_q >= 5'h02 && !rd_q |-> !serial_out)
        else $error("device drove data in a write frame");
    a_idle_quiet: assert property (
        !ce && !$past(ce, 8) |-> !serial_out)
        else $error("device drove data between frames");
    a_cmd_gap: assert property (
        $rose(ce) |-> lo_q >= 8'(lsp_pkg::CMD_WAIT_CYC))
        else $error("next frame started inside the command gap");
    c_read: cover property (ce && rd_q && serial_out);
    c_write: cover property ($fell(ce) && !rd_q);
    c_frame: cover property ($fell(ce) && cnt_q == 5'h10);
endmodule

// ### sim/tb_top.sv
// testbench: host and device joined by the link, driven over Wishbone
// assumes the design defaults for clock divider and command gap
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic chk = 1'b0;
    logic ack;
    logic wr_stb;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] sel_w = 4'hF;
    logic [7:0] wa, wd, a, d;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, q;
    logic [15:0] wq[$];
    logic [31:0] rq[$];
    logic [7:0] mem[bit [7:0]];
    logic [7:0] addrs[$];
    integer seed = 32'h9FD61651;
    int mismatches = 0;
    int n_compared = 0;
    lsp_link_if link();
    lsp_host lsp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
    lsp_dev lsp_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .wr_stb_o(wr_stb), .wr_addr_o(wa), .wr_data_o(wd));
    lsp_link_sva lsp_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(link.sclk), .ce(link.ce), .serial_in(link.serial_in),
        .serial_out(link.serial_out));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wdat);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= wdat;
        sel <= sel_w;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk <= 1'b0;
    endtask
    // poll until the host is no longer busy
    task automatic idle;
        int n = 0;
        do begin
            wb(1'b0, lsp_pkg::REG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 600);
        if (n >= 600) mismatches++;
    endtask
    task automatic cmd(input logic [7:0] ca, input logic [7:0] cd);
        idle();
        wb(1'b1, lsp_pkg::REG_CMD, {16'h0000, ca, cd});
    endtask
    task automatic rd(input logic [7:0] ra, input logic [31:0] e);
        idle();
        rq.push_back(e);
        chk <= 1'b1;
        wb(1'b0, ra, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (ack === 1'b1 && chk === 1'b1) begin
            check(rdat, rq.pop_front(), "read");
        end
        if (wr_stb === 1'b1) begin
            check({16'h0, wa, wd}, wq.size() ? {16'h0, wq.pop_front()}
                  : 32'hFFFFFFFF, "write");
        end
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(lsp_pkg::REG_STATUS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 8'h6A : 8'($unsigned($random(seed)) % 107);
            d = 8'($random(seed));
            cmd(a, d);
            wq.push_back({a, d});
            mem[a] = d;
            addrs.push_back(a);
        end
        // test area reads back its reset value
        cmd(8'hEB, 8'h00);
        rd(lsp_pkg::REG_STATUS, 32'h0);
        // write into the test area is refused and sends no frame
        cmd(8'h6B, 8'hA5);
        rd(lsp_pkg::REG_STATUS, 32'h0000_0002);
        foreach (addrs[i]) begin
            cmd(addrs[i] | 8'h80, 8'h00);
            rd(lsp_pkg::REG_STATUS, {16'h0, mem[addrs[i]], 8'h00});
        end
        // command without both low byte lanes is ignored: no frame, no write
        sel_w = 4'h0;
        cmd(8'h10, 8'h5A);
        sel_w = 4'hF;
        wb(1'b1, 8'h0C, 32'($random(seed)));
        rd(8'h0C, 32'h0);
        check(32'(wq.size()), 32'h0, "pending writes");
        tally_and_finish();
    end
endmodule
